// ===== logic/vrcc_device.sv
/*
  Device end of the redriver configuration control: power-down and standby,
  register file, strap sampling, lane equalisation and swap, termination.
  Assumes the host end drives the link interface synchronously to sys_clk.
*/
`default_nettype none
// Notes on behaviour
// - Power down on hot-plug low, bit, or pin
// - Chip-active low clears registers; host reprograms
// - Chip-active low ignores controls, video high-impedance
// - Chip-active held low at least 100 us
// - Automatic code returns high-rate termination only when ratio flag set
// - No valid clock with detect enabled means standby
// - Clock loss readable in status register bit
// - Sideband runs slow by default, software may speed
// - Bus address from address straps under host config
// - Global lane control default; bit selects independent
// - Lane registers and equalisation nibbles per lane
// - Host rewrites lane settings after swap with independent
// - Lane settings follow swapped mapping
// - Swap from strap or register bit per config
// - Three-level strap pair decodes to nine gains
// - Global 4-bit equalisation field maps sixteen gains
// - Per-lane nibbles by unswapped pins; clock lane takes the global field, not the high nibble
// - Clock lane equalisation from two-bit global field under host config
// - Termination from strap or register code
// - Ratio flag set forces high-rate termination
// - Chip-active held low until supplies stable
// - Code 10 automatic, code 11 high-rate termination
// - Hot-plug low clears ratio flag when automatic
module vrcc_device (
  input wire logic sys_clk,
  input wire logic reset_n,
  vrcc_link_if.dev link,
  input wire logic hot_plug_sense,
  input wire logic clock_valid,
  input wire logic snoop_wr,
  input wire logic snoop_wr_value,
  input wire logic snoop_rd,
  input wire logic snoop_rd_value,
  output logic powered_down,
  output logic standby,
  output logic video_hiz,
  output logic lane_swap_active,
  output logic [15:0] lane_eq,
  output logic [19:0] lane_drive,
  output logic [1:0] term_sel,
  output logic sideband_fast,
  output logic [1:0] bus_addr
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic active_seen;
    logic [7:0] mode;
    logic [7:0] term;
    logic [7:0] eq;
    logic [3:0][4:0] lane_cfg;
    logic [7:0] leq_lo;
    logic [7:0] leq_hi;
    logic [3:0] strap_eq;
    logic strap_swap;
    logic [1:0] strap_term;
    logic [1:0] addr;
    logic loss;
    logic [7:0] rdata;
  } vrcc_dev_s;

  vrcc_dev_s state_reg;
  vrcc_dev_s state_next;
  logic [3:0] strap_eq_code;
  logic cfg_host;
  logic [3:0][3:0] pin_eq;
  logic [1:0] term_code;
  logic [2:0] lane_idx;

  vrcc_eq_decode eq_dec (
    .eq_high(link.addr1_eq_high_strap),
    .eq_low(link.addr0_eq_low_strap),
    .eq_code(strap_eq_code)
  );

  assign lane_idx = 3'(link.reg_addr - vrcc_pkg::DEV_LANE0_OFS);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rdata = 8'h00;
    if (!link.chip_active) begin
      state_next = '0;
      state_next.mode = vrcc_pkg::DEV_MODE_RST;
      state_next.term = vrcc_pkg::DEV_REG_RST;
      state_next.eq = vrcc_pkg::DEV_REG_RST;
    end else begin
      state_next.active_seen = 1'b1;
      if (!state_reg.active_seen) begin
        state_next.strap_eq = strap_eq_code;
        state_next.strap_swap = link.lane_swap_strap;
        state_next.strap_term = link.term_strap;
        state_next.addr = {link.addr1_eq_high_strap == vrcc_pkg::LVL_HIGH,
                           link.addr0_eq_low_strap == vrcc_pkg::LVL_HIGH};
      end
      if (link.reg_wr) begin
        case (link.reg_addr)
          vrcc_pkg::DEV_MODE_OFS: state_next.mode = link.reg_wdata;
          vrcc_pkg::DEV_TERM_OFS: state_next.term = link.reg_wdata;
          vrcc_pkg::DEV_EQ_OFS: state_next.eq = link.reg_wdata;
          vrcc_pkg::DEV_LEQ_LO_OFS: state_next.leq_lo = link.reg_wdata;
          vrcc_pkg::DEV_LEQ_HI_OFS: state_next.leq_hi = link.reg_wdata;
          default: begin
            if (link.reg_addr >= vrcc_pkg::DEV_LANE0_OFS
                && link.reg_addr <= vrcc_pkg::DEV_LANE3_OFS) begin
              state_next.lane_cfg[lane_idx[1:0]] = link.reg_wdata[7:3];
            end
          end
        endcase
      end
      // Ratio flag follows the sideband snoop unless snooping is off
      if (!state_reg.term[vrcc_pkg::TERM_NOSNOOP_BIT]
          && !(link.reg_wr && link.reg_addr == vrcc_pkg::DEV_TERM_OFS
               && link.reg_wdata[vrcc_pkg::TERM_NOSNOOP_BIT])) begin
        state_next.term[vrcc_pkg::TERM_RATIO_BIT] = state_reg.term[vrcc_pkg::TERM_RATIO_BIT];
        if (!hot_plug_sense) begin
          state_next.term[vrcc_pkg::TERM_RATIO_BIT] = 1'b0;
        end else if (snoop_wr) begin
          state_next.term[vrcc_pkg::TERM_RATIO_BIT] = snoop_wr_value;
        end else if (snoop_rd && snoop_rd_value) begin
          state_next.term[vrcc_pkg::TERM_RATIO_BIT] = 1'b1;
        end
      end
      if (link.reg_rd) begin
        case (link.reg_addr)
          vrcc_pkg::DEV_MODE_OFS: state_next.rdata = state_reg.mode;
          vrcc_pkg::DEV_TERM_OFS: state_next.rdata = state_reg.term;
          vrcc_pkg::DEV_EQ_OFS: state_next.rdata = state_reg.eq;
          vrcc_pkg::DEV_STAT_OFS: begin
            state_next.rdata[vrcc_pkg::STAT_LOSS_BIT] = state_reg.loss;
          end
          vrcc_pkg::DEV_LEQ_LO_OFS: state_next.rdata = state_reg.leq_lo;
          vrcc_pkg::DEV_LEQ_HI_OFS: state_next.rdata = state_reg.leq_hi;
          default: begin
            if (link.reg_addr >= vrcc_pkg::DEV_LANE0_OFS
                && link.reg_addr <= vrcc_pkg::DEV_LANE3_OFS) begin
              state_next.rdata = {state_reg.lane_cfg[lane_idx[1:0]], 3'h0};
            end
          end
        endcase
      end
      state_next.loss = state_reg.mode[vrcc_pkg::MODE_CDE_BIT] && !clock_valid;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------------
  assign powered_down = !link.chip_active || !hot_plug_sense
                        || state_reg.mode[vrcc_pkg::MODE_PD_BIT];
  assign standby = link.chip_active && state_reg.loss;
  assign video_hiz = powered_down || standby;
  assign sideband_fast = state_reg.mode[vrcc_pkg::MODE_FAST_BIT];
  assign bus_addr = cfg_host ? state_reg.addr : 2'h0;
  assign link.reg_rdata = state_reg.rdata;

  // ----------------------------------------------------------------------
  // Lane control
  // ----------------------------------------------------------------------
  assign cfg_host = link.cfg_select && state_reg.active_seen;
  assign lane_swap_active = cfg_host ? state_reg.mode[vrcc_pkg::MODE_SWAP_BIT]
                                     : state_reg.strap_swap;

  always_comb begin
    pin_eq = '0;
    if (!cfg_host) begin
      pin_eq = {4{state_reg.strap_eq}};
    end else if (state_reg.mode[vrcc_pkg::MODE_INDEP_BIT]) begin
      pin_eq[0] = state_reg.leq_hi[7:4];
      pin_eq[1] = state_reg.leq_hi[3:0];
      pin_eq[2] = state_reg.leq_lo[7:4];
      pin_eq[3] = state_reg.leq_lo[3:0];
    end else begin
      pin_eq = {4{state_reg.eq[6:3]}};
    end
    if (cfg_host) begin
      pin_eq[0] = {2'h0, state_reg.eq[2:1]};
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (lane_swap_active) begin
        lane_eq[i*4 +: 4] = pin_eq[3-i];
        lane_drive[i*5 +: 5] = state_reg.mode[vrcc_pkg::MODE_INDEP_BIT]
                               ? state_reg.lane_cfg[3-i] : state_reg.lane_cfg[0];
      end else begin
        lane_eq[i*4 +: 4] = pin_eq[i];
        lane_drive[i*5 +: 5] = state_reg.mode[vrcc_pkg::MODE_INDEP_BIT]
                               ? state_reg.lane_cfg[i] : state_reg.lane_cfg[0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Source termination
  // ----------------------------------------------------------------------
  assign term_code = cfg_host ? state_reg.term[4:3] : state_reg.strap_term;

  always_comb begin
    term_sel = term_code;
    if (state_reg.term[vrcc_pkg::TERM_RATIO_BIT]) begin
      term_sel = vrcc_pkg::TERM_HIGH_RATE;
    end else if (term_code == vrcc_pkg::TERM_AUTO) begin
      term_sel = vrcc_pkg::TERM_NONE;
    end
  end
endmodule : vrcc_device
`default_nettype wire

// ===== logic/vrcc_pkg.sv
/*
  Shared constants of the video redriver configuration control: register
  offsets, field positions, reset values, three-level strap codes, timing.
  Assumes a single 250 MHz system clock on both ends.
*/
`default_nettype none
package vrcc_pkg;
  // ----------------------------------------------------------------------
  // Device register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] DEV_MODE_OFS = 8'h09;
  localparam logic [7:0] DEV_TERM_OFS = 8'h0B;
  localparam logic [7:0] DEV_EQ_OFS = 8'h0D;
  localparam logic [7:0] DEV_STAT_OFS = 8'h20;
  localparam logic [7:0] DEV_LANE0_OFS = 8'h31;
  localparam logic [7:0] DEV_LANE3_OFS = 8'h34;
  localparam logic [7:0] DEV_LEQ_LO_OFS = 8'h4E;
  localparam logic [7:0] DEV_LEQ_HI_OFS = 8'h4F;
  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int MODE_SWAP_BIT = 7;
  localparam int MODE_INDEP_BIT = 5;
  localparam int MODE_PD_BIT = 3;
  localparam int MODE_CDE_BIT = 2;
  localparam int MODE_FAST_BIT = 0;
  localparam int TERM_RATIO_BIT = 1;
  localparam int TERM_NOSNOOP_BIT = 0;
  localparam int STAT_LOSS_BIT = 5;
  localparam logic [7:0] DEV_MODE_RST = 8'h04;
  localparam logic [7:0] DEV_REG_RST = 8'h00;
  // ----------------------------------------------------------------------
  // Termination codes and three-level strap levels
  // ----------------------------------------------------------------------
  localparam logic [1:0] TERM_MID = 2'h0;
  localparam logic [1:0] TERM_NONE = 2'h1;
  localparam logic [1:0] TERM_AUTO = 2'h2;
  localparam logic [1:0] TERM_HIGH_RATE = 2'h3;
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [1:0] LVL_FLOAT = 2'h2;
  // ----------------------------------------------------------------------
  // Host register offsets and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] HST_CTRL_OFS = 8'h00;
  localparam logic [7:0] HST_STRAP_OFS = 8'h01;
  localparam logic [7:0] HST_DADDR_OFS = 8'h02;
  localparam logic [7:0] HST_DDATA_OFS = 8'h03;
  localparam logic [7:0] HST_DREAD_OFS = 8'h04;
  localparam logic [7:0] HST_STAT_OFS = 8'h05;
  localparam int CLK_MHZ = 250;
  localparam int OFF_MIN_US = 100;
  localparam int OFF_MIN_CYCLES = OFF_MIN_US * CLK_MHZ;
endpackage : vrcc_pkg
`default_nettype wire

// ===== logic/vrcc_link_if.sv
/*
  Connection between the management host end and the redriver device end:
  chip-active pin, strap levels and the device register port.
  Assumes both ends run on the same sys_clk.
*/
`default_nettype none
interface vrcc_link_if;
  logic chip_active;
  logic cfg_select;
  logic [1:0] addr0_eq_low_strap;
  logic [1:0] addr1_eq_high_strap;
  logic lane_swap_strap;
  logic [1:0] term_strap;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  modport dev (
    input chip_active, cfg_select, addr0_eq_low_strap, addr1_eq_high_strap,
    input lane_swap_strap, term_strap, reg_addr, reg_wdata, reg_wr, reg_rd,
    output reg_rdata
  );
  modport host (
    output chip_active, cfg_select, addr0_eq_low_strap, addr1_eq_high_strap,
    output lane_swap_strap, term_strap, reg_addr, reg_wdata, reg_wr, reg_rd,
    input reg_rdata
  );
endinterface : vrcc_link_if
`default_nettype wire

// ===== logic/vrcc_eq_decode.sv
/*
  Decoder from the two three-level equalisation straps to the 4-bit
  equalisation code. Assumes levels coded as in vrcc_pkg.
*/
`default_nettype none
module vrcc_eq_decode (
  input wire logic [1:0] eq_high,
  input wire logic [1:0] eq_low,
  output logic [3:0] eq_code
);
  always_comb begin
    eq_code = 4'h0;
    case ({eq_high, eq_low})
      {vrcc_pkg::LVL_LOW, vrcc_pkg::LVL_LOW}: eq_code = 4'h0;
      {vrcc_pkg::LVL_LOW, vrcc_pkg::LVL_FLOAT}: eq_code = 4'h1;
      {vrcc_pkg::LVL_LOW, vrcc_pkg::LVL_HIGH}: eq_code = 4'h3;
      {vrcc_pkg::LVL_FLOAT, vrcc_pkg::LVL_LOW}: eq_code = 4'h4;
      {vrcc_pkg::LVL_FLOAT, vrcc_pkg::LVL_FLOAT}: eq_code = 4'h6;
      {vrcc_pkg::LVL_FLOAT, vrcc_pkg::LVL_HIGH}: eq_code = 4'h8;
      {vrcc_pkg::LVL_HIGH, vrcc_pkg::LVL_LOW}: eq_code = 4'h9;
      {vrcc_pkg::LVL_HIGH, vrcc_pkg::LVL_FLOAT}: eq_code = 4'hD;
      {vrcc_pkg::LVL_HIGH, vrcc_pkg::LVL_HIGH}: eq_code = 4'hF;
      default: eq_code = 4'h0;
    endcase
  end
endmodule : vrcc_eq_decode
`default_nettype wire

// ===== logic/vrcc_host.sv
/*
  Management host end: drives the chip-active pin with its off time and
  supply gating, sets strap levels, and forwards software register access
  to the device. Assumes a software port with read data one cycle later.
*/
`default_nettype none
module vrcc_host #(
  parameter int OFF_CYCLES = vrcc_pkg::OFF_MIN_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  vrcc_link_if.host link,
  input wire logic supplies_stable,
  input wire logic [7:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] ctrl;
    logic [6:0] straps;
    logic [7:0] daddr;
    logic [7:0] dwdata;
    logic dwr;
    logic drd;
    logic drd_wait;
    logic [7:0] drdata;
    logic [15:0] off_cnt;
    logic active;
    logic programmed;
    logic reprogram;
    logic [7:0] rdata;
  } vrcc_host_s;

  vrcc_host_s state_reg;
  vrcc_host_s state_next;
  logic off_met;

  assign off_met = 32'(state_reg.off_cnt) >= OFF_CYCLES;

  always_comb begin
    state_next = state_reg;
    state_next.dwr = 1'b0;
    state_next.drd = 1'b0;
    state_next.rdata = 8'h00;
    state_next.drd_wait = state_reg.drd;
    if (state_reg.drd_wait) begin
      state_next.drdata = link.reg_rdata;
    end
    if (!state_reg.active && !off_met) begin
      state_next.off_cnt = state_reg.off_cnt + 16'h0001;
    end
    if (state_reg.active) begin
      state_next.off_cnt = 16'h0000;
    end
    state_next.active = state_reg.ctrl[0] && supplies_stable
                        && (state_reg.active || off_met);
    if (state_next.active && !state_reg.active && state_reg.programmed) begin
      state_next.reprogram = 1'b1;
      state_next.programmed = 1'b0;
    end
    if (sw_wr) begin
      case (sw_addr)
        vrcc_pkg::HST_CTRL_OFS: state_next.ctrl = sw_wdata[1:0];
        vrcc_pkg::HST_STRAP_OFS: state_next.straps = sw_wdata[6:0];
        vrcc_pkg::HST_DADDR_OFS: state_next.daddr = sw_wdata;
        vrcc_pkg::HST_DDATA_OFS: begin
          state_next.dwdata = sw_wdata;
          state_next.dwr = state_next.active;
          state_next.programmed = state_next.active;
        end
        vrcc_pkg::HST_DREAD_OFS: state_next.drd = state_next.active;
        vrcc_pkg::HST_STAT_OFS: begin
          if (sw_wdata[1]) begin
            state_next.reprogram = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // A fresh reason to reprogram wins over a clear in the same cycle
    if (sw_wr && sw_addr == vrcc_pkg::HST_DDATA_OFS && state_next.active
        && state_reg.daddr == vrcc_pkg::DEV_MODE_OFS
        && sw_wdata[vrcc_pkg::MODE_SWAP_BIT] && sw_wdata[vrcc_pkg::MODE_INDEP_BIT]) begin
      state_next.reprogram = 1'b1;
    end
    if (state_next.active && !state_reg.active && state_reg.programmed) begin
      state_next.reprogram = 1'b1;
    end
    if (sw_rd) begin
      case (sw_addr)
        vrcc_pkg::HST_CTRL_OFS: state_next.rdata = {6'h00, state_reg.ctrl};
        vrcc_pkg::HST_STRAP_OFS: state_next.rdata = {1'b0, state_reg.straps};
        vrcc_pkg::HST_DADDR_OFS: state_next.rdata = state_reg.daddr;
        vrcc_pkg::HST_DDATA_OFS: state_next.rdata = state_reg.drdata;
        vrcc_pkg::HST_STAT_OFS: begin
          state_next.rdata = {5'h00, off_met, state_reg.reprogram, state_reg.active};
        end
        default: state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Link drive
  // ----------------------------------------------------------------------
  assign link.chip_active = state_reg.active;
  assign link.cfg_select = state_reg.ctrl[1];
  assign link.addr0_eq_low_strap = state_reg.straps[1:0];
  assign link.addr1_eq_high_strap = state_reg.straps[3:2];
  assign link.lane_swap_strap = state_reg.straps[4];
  assign link.term_strap = state_reg.straps[6:5];
  assign link.reg_addr = state_reg.daddr;
  assign link.reg_wdata = state_reg.dwdata;
  assign link.reg_wr = state_reg.dwr;
  assign link.reg_rd = state_reg.drd;
  assign sw_rdata = state_reg.rdata;
endmodule : vrcc_host
`default_nettype wire

// ===== testbench/vrcc_chk.sv
/*
  Checker of the link between the host end and the device end.
  Assumes one sys_clk and an instance beside the link interface.
*/
`default_nettype none
module vrcc_chk #(
  parameter int OFF_CYCLES = vrcc_pkg::OFF_MIN_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic chip_active,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------------
  // Shadow of what the device registers should hold
  // ----------------------------------------------------------------------
  int low_cnt;
  logic mode_dirty;
  logic [7:0] eq_sh;
  logic [7:0] term_sh;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= 0;
      mode_dirty <= 1'b0;
      eq_sh <= 8'h00;
      term_sh <= 8'h00;
    end else if (!chip_active) begin
      low_cnt <= low_cnt + 1;
      mode_dirty <= 1'b0;
      eq_sh <= 8'h00;
      term_sh <= 8'h00;
    end else begin
      low_cnt <= 0;
      if (reg_wr && reg_addr == vrcc_pkg::DEV_MODE_OFS) mode_dirty <= 1'b1;
      if (reg_wr && reg_addr == vrcc_pkg::DEV_EQ_OFS) eq_sh <= reg_wdata;
      if (reg_wr && reg_addr == vrcc_pkg::DEV_TERM_OFS) term_sh <= reg_wdata;
    end
  end
  sequence s_mode_read;
    chip_active && reg_rd && reg_addr == vrcc_pkg::DEV_MODE_OFS && !mode_dirty;
  endsequence
  sequence s_eq_read;
    chip_active && reg_rd && reg_addr == vrcc_pkg::DEV_EQ_OFS;
  endsequence
  sequence s_term_read;
    chip_active && reg_rd && reg_addr == vrcc_pkg::DEV_TERM_OFS;
  endsequence
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_strobes_apart: assert property (!(reg_wr && reg_rd))
    else $error("device write and read strobes together");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("device read data outside its cycle");
  a_off_silent: assert property (!chip_active |-> !reg_wr && !reg_rd)
    else $error("device access forwarded while chip inactive");
  a_off_time: assert property ($rose(chip_active) |-> low_cnt >= OFF_CYCLES)
    else $error("chip active raised before off time");
  a_min_low: assert property ($fell(chip_active) |-> !chip_active [*8])
    else $error("chip active low pulse too short");
  a_mode_reset: assert property (s_mode_read |=> reg_rdata == vrcc_pkg::DEV_MODE_RST)
    else $error("mode register not at reset value");
  a_eq_echo: assert property (s_eq_read |=> (reg_rdata & 8'h7E) == ($past(eq_sh) & 8'h7E))
    else $error("equalisation register read back wrong");
  a_term_echo: assert property (s_term_read |=> (reg_rdata & 8'h18) == ($past(term_sh) & 8'h18))
    else $error("termination code read back wrong");
endmodule : vrcc_chk
`default_nettype wire

// ===== testbench/test_video_redriver_config_control.sv
/*
  Testbench: host and device ends joined by the link interface.
  Assumes package, interface, design modules and checker compiled first.
*/
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module test_video_redriver_config_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OFFC = 20;
  logic sys_clk, reset_n, supplies_stable, hot_plug_sense, clock_valid;
  logic snoop_wr, snoop_wr_value, snoop_rd, snoop_rd_value, sw_wr, sw_rd;
  logic [7:0] sw_addr, sw_wdata, sw_rdata;
  logic powered_down, standby, video_hiz, lane_swap_active, sideband_fast;
  logic [15:0] lane_eq;
  logic [19:0] lane_drive;
  logic [1:0] term_sel, bus_addr, ck;
  logic [3:0] code;
  logic [7:0] exp_q[$], msk_q[$];
  logic rd_seen;
  int n_mismatch, checks, cyc, seed;
  logic [1:0] lvl[3] = '{vrcc_pkg::LVL_LOW, vrcc_pkg::LVL_FLOAT, vrcc_pkg::LVL_HIGH};
  logic [3:0] eqtab[9] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'hD, 4'hF};
  logic [1:0] texp[4] = '{2'h0, 2'h1, 2'h1, 2'h3};
  vrcc_link_if link ();
  vrcc_host #(.OFF_CYCLES(OFFC)) u_vrcc_host (.sys_clk(sys_clk), .reset_n(reset_n),
    .link(link), .supplies_stable(supplies_stable), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  vrcc_device u_vrcc_device (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
    .hot_plug_sense(hot_plug_sense), .clock_valid(clock_valid), .snoop_wr(snoop_wr),
    .snoop_wr_value(snoop_wr_value), .snoop_rd(snoop_rd), .snoop_rd_value(snoop_rd_value),
    .powered_down(powered_down), .standby(standby), .video_hiz(video_hiz),
    .lane_swap_active(lane_swap_active), .lane_eq(lane_eq), .lane_drive(lane_drive),
    .term_sel(term_sel), .sideband_fast(sideband_fast), .bus_addr(bus_addr));
  vrcc_chk #(.OFF_CYCLES(OFFC)) u_vrcc_chk (.sys_clk(sys_clk), .reset_n(reset_n),
    .chip_active(link.chip_active), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata));
  // ----------------------------------------------------------------------
  // Clock, timeout, read monitor and bus tasks
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  always @(posedge sys_clk) begin : mon
    logic [7:0] m, e;
    if (rd_seen) begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      `CHK(sw_rdata & m, e)
    end
    rd_seen <= sw_rd;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic sw_cyc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sw_wr <= wr;
    sw_rd <= !wr;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
  endtask : sw_cyc
  task automatic sw_rdx(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    sw_cyc(1'b0, a, 8'h00);
  endtask : sw_rdx
  task automatic dev_wr(input logic [7:0] o, input logic [7:0] d);
    sw_cyc(1'b1, vrcc_pkg::HST_DADDR_OFS, o);
    sw_cyc(1'b1, vrcc_pkg::HST_DDATA_OFS, d);
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : dev_wr
  task automatic dev_rd(input logic [7:0] o, input logic [7:0] e, input logic [7:0] m);
    sw_cyc(1'b1, vrcc_pkg::HST_DADDR_OFS, o);
    sw_cyc(1'b1, vrcc_pkg::HST_DREAD_OFS, 8'h00);
    repeat (3) @(posedge sys_clk);
    sw_rdx(vrcc_pkg::HST_DDATA_OFS, e, m);
  endtask : dev_rd
  task automatic power_up(input logic [7:0] straps, input logic [7:0] ctrl);
    sw_cyc(1'b1, vrcc_pkg::HST_CTRL_OFS, 8'h00);
    sw_cyc(1'b1, vrcc_pkg::HST_STRAP_OFS, straps);
    #1;
    `CHK(video_hiz, 1'b1)
    sw_cyc(1'b1, vrcc_pkg::HST_CTRL_OFS, ctrl);
    for (int k = 0; k < 200 && link.chip_active !== 1'b1; k++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : power_up
  task automatic snoop(input logic rd, input logic v);
    @(posedge sys_clk);
    snoop_wr <= !rd;
    snoop_rd <= rd;
    snoop_wr_value <= v;
    snoop_rd_value <= v;
    @(posedge sys_clk);
    snoop_wr <= 1'b0;
    snoop_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : snoop
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {reset_n, sw_wr, sw_rd, snoop_wr, snoop_rd, snoop_wr_value, snoop_rd_value} = '0;
    {sw_addr, sw_wdata, rd_seen, cyc, n_mismatch, checks} = '0;
    {supplies_stable, hot_plug_sense, clock_valid} = 3'b111;
    seed = 6582;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1;
    `CHK(powered_down, 1'b1)
    for (int i = 0; i < 9; i++) begin
      power_up({3'b000, i[0], lvl[i / 3], lvl[i % 3]}, 8'h01);
      `CHK(lane_eq[7:4], eqtab[i])
      `CHK(lane_swap_active, i[0])
    end
    power_up({4'h0, vrcc_pkg::LVL_FLOAT, vrcc_pkg::LVL_HIGH}, 8'h03);
    `CHK(bus_addr, 2'b01)
    `CHK(powered_down, 1'b0)
    `CHK(sideband_fast, 1'b0)
    dev_rd(vrcc_pkg::DEV_MODE_OFS, vrcc_pkg::DEV_MODE_RST, 8'hFF);
    sw_rdx(8'hF0, 8'h00, 8'hFF);
    dev_wr(vrcc_pkg::DEV_MODE_OFS, 8'h0C);
    `CHK(powered_down, 1'b1)
    dev_wr(vrcc_pkg::DEV_MODE_OFS, 8'h05);
    `CHK(powered_down, 1'b0)
    `CHK(sideband_fast, 1'b1)
    @(posedge sys_clk) clock_valid <= 1'b0;
    dev_rd(vrcc_pkg::DEV_STAT_OFS, 8'h20, 8'h20);
    `CHK(standby, 1'b1)
    @(posedge sys_clk) clock_valid <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      code = i[3:0];
      ck = 2'($random(seed));
      dev_wr(vrcc_pkg::DEV_EQ_OFS, {1'b0, code, ck, 1'b0});
      `CHK(lane_eq, {code, code, code, 2'b00, ck})
    end
    for (int i = 0; i < 4; i++) begin
      dev_wr(vrcc_pkg::DEV_TERM_OFS, {3'b000, i[1:0], 3'b000});
      `CHK(term_sel, texp[i])
    end
    dev_wr(vrcc_pkg::DEV_TERM_OFS, 8'h10);
    snoop(1'b0, 1'b1);
    `CHK(term_sel, vrcc_pkg::TERM_HIGH_RATE)
    dev_rd(vrcc_pkg::DEV_TERM_OFS, 8'h12, 8'h1A);
    @(posedge sys_clk) hot_plug_sense <= 1'b0;
    @(posedge sys_clk) hot_plug_sense <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(term_sel, vrcc_pkg::TERM_NONE)
    snoop(1'b1, 1'b1);
    `CHK(term_sel, vrcc_pkg::TERM_HIGH_RATE)
    dev_wr(vrcc_pkg::DEV_LEQ_HI_OFS, 8'hA5);
    dev_wr(vrcc_pkg::DEV_LEQ_LO_OFS, 8'h3C);
    dev_wr(vrcc_pkg::DEV_MODE_OFS, 8'h24);
    `CHK(lane_eq[15:4], 12'hC35)
    dev_wr(8'h33, 8'hB8);
    `CHK(lane_drive[14:10], 5'h17)
    dev_rd(8'h33, 8'hB8, 8'hFF);
    dev_wr(vrcc_pkg::DEV_MODE_OFS, 8'hA4);
    `CHK(lane_eq[11:4], 8'h53)
    `CHK(lane_swap_active, 1'b1)
    `CHK(lane_drive[9:5], 5'h17)
    sw_rdx(vrcc_pkg::HST_STAT_OFS, 8'h03, 8'h07);
    sw_cyc(1'b1, vrcc_pkg::HST_STAT_OFS, 8'h02);
    sw_rdx(vrcc_pkg::HST_STAT_OFS, 8'h01, 8'h07);
    power_up(8'h00, 8'h03);
    `CHK(lane_swap_active, 1'b0)
    sw_rdx(vrcc_pkg::HST_STAT_OFS, 8'h03, 8'h07);
    dev_rd(vrcc_pkg::DEV_EQ_OFS, 8'h00, 8'hFF);
    dev_rd(vrcc_pkg::DEV_MODE_OFS, vrcc_pkg::DEV_MODE_RST, 8'hFF);
    repeat (4) @(posedge sys_clk);
    conclude();
  end
endmodule : test_video_redriver_config_control
`default_nettype wire
